// ===== ufte_top.sv
// The register addresses and the APB slave port were decided locally.
`default_nettype none
// Operation
// - Start, 7/8 data, parity option, 1/2 stops
// - Bit order chosen by control bit 1
// - Output polarity chosen by control bit 0
// - Even parity generated and checked
// - Odd parity generated and checked
// - Zero parity sends 0, never errors
// - No parity bit, never errors
// - Buffer moves to shifter, framing added
// - Transmit done right after last stop
// - Idle level held until next write
// - Buffer writable once shifting starts
// - Buffer full flag at status bit 1
// - Shift busy flag at status bit 0
// - Flags pass 10, 01, 00
// - Receive runs with power and enable
// - Falling edge, half count, low confirms start
// - Stop copies data, skipped on overrun
// - Parity error does not abort frame
// - Receiver checks exactly one stop bit
// - Reading error register clears it
// - Overrun on unread buffer, framing on stop
// - Power off clears unit, enables reset halves
module ufte_top (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [ufte_pkg::AW-1:0] paddr,
  input  wire logic [31:0]             pwdata,
  output var  logic [31:0]             prdata,
  output var  logic                    pready,
  output var  logic                    pslverr,
  input  wire logic                    serial_in_pin,
  output var  logic                    serial_out_pin,
  output var  logic                    tx_done_irq,
  output var  logic                    rx_done_irq,
  output var  logic                    rx_error_irq
);
  import ufte_pkg::*;

  // Keep only the character bits
  function automatic logic [7:0] chr(input logic [7:0] d, input logic l8);
    chr = l8 ? d : {1'b0, d[6:0]};
  endfunction

  // Reverse the character bits in place
  function automatic logic [7:0] rev(input logic [7:0] d, input logic l8);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) r[7-i] = d[i];
    rev = l8 ? r : {1'b0, r[7:1]};
  endfunction

  // Register state
  logic [7:0]  mode_q;
  logic [7:0]  ctrl_q;
  logic [7:0]  div_q;
  logic [7:0]  txb_q;
  logic [7:0]  rxb_q;
  logic [2:0]  err_q;
  logic        txf_q;
  logic        unread_q;
  logic        pready_q;

  logic        pwr;
  logic        tx_on;
  logic        rx_on;
  logic [1:0]  par;
  logic        len8;
  logic        lsb;
  logic        inv;
  logic [2:0]  last_bit;
  logic [8:0]  bit_top;
  logic [8:0]  half_top;

  assign pwr      = mode_q[MODE_PWR];
  assign tx_on    = pwr & mode_q[MODE_TXE];
  assign rx_on    = pwr & mode_q[MODE_RXE];
  assign par      = mode_q[MODE_PS +: 2];
  assign len8     = mode_q[MODE_CL];
  assign lsb      = ctrl_q[CTRL_DIR];
  assign inv      = ctrl_q[CTRL_INV];
  assign last_bit = len8 ? LAST8 : LAST7;
  // One bit lasts twice the divisor; start is checked at half
  assign bit_top  = {div_q, 1'b0} - 9'h001;
  assign half_top = {1'b0, div_q} - 9'h001;

  // APB strobes; the answer is registered, so one wait state
  logic        setup_rd;
  logic        acc;
  logic        wr;
  logic        rd;
  logic [31:0] rd_val;
  logic        hit;

  assign setup_rd = psel & penable & ~pready_q;
  assign acc      = psel & penable & pready_q;
  assign wr       = acc & pwrite;
  assign rd       = acc & ~pwrite;

  // Transmit engine state
  ufte_tx_st_t tx_st_q;
  logic [8:0]  txc_q;
  logic [7:0]  txs_q;
  logic [7:0]  txd_q;
  logic [2:0]  txn_q;
  logic        txp_q;
  logic        txs2_q;
  logic        tx_end;
  logic        tx_fin;
  logic        tx_load;
  logic        tx_wr;
  logic        tx_busy;

  // Receive engine state
  ufte_rx_st_t rx_st_q;
  logic [8:0]  rxc_q;
  logic [7:0]  rxs_q;
  logic [2:0]  rxn_q;
  logic        rxx_q;
  logic        rxpe_q;
  logic        rxprev_q;
  logic        rx_fin;
  logic        rx_end;
  logic [7:0]  rx_data;
  logic [2:0]  rx_errs;
  logic        rd_err;
  logic        rd_rxb;

  // Read mux and unmapped-address decode
  always_comb begin
    rd_val = 32'h0000_0000;
    hit    = 1'b1;
    if (paddr == OFS_MODE) begin
      rd_val[7:0] = mode_q;
    end else if (paddr == OFS_CTRL) begin
      rd_val[7:0] = ctrl_q;
    end else if (paddr == OFS_BAUD) begin
      rd_val[7:0] = div_q;
    end else if (paddr == OFS_TXB) begin
      rd_val[7:0] = txb_q;
    end else if (paddr == OFS_RXB) begin
      rd_val[7:0] = rxb_q;
    end else if (paddr == OFS_TXS) begin
      rd_val[TXS_FULL] = txf_q;
      rd_val[TXS_BUSY] = tx_busy;
    end else if (paddr == OFS_ERR) begin
      rd_val[2:0] = err_q;
    end else begin
      hit = 1'b0;
    end
  end

  // Bus answer flops
  always_ff @(posedge clk) begin
    if (rst) begin
      pready_q <= 1'b0;
      prdata   <= 32'h0000_0000;
      pslverr  <= 1'b0;
    end else begin
      pready_q <= setup_rd | (psel & penable & pwrite & ~pready_q);
      prdata   <= setup_rd ? rd_val : 32'h0000_0000;
      pslverr  <= psel & penable & ~pready_q & ~hit;
    end
  end
  assign pready = pready_q;

  // Software-written configuration
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_q <= MODE_RST;
      ctrl_q <= CTRL_RST;
      div_q  <= BAUD_RST;
    end else if (wr) begin
      if (paddr == OFS_MODE) mode_q <= pwdata[7:0];
      if (paddr == OFS_CTRL) ctrl_q <= pwdata[7:0];
      if (paddr == OFS_BAUD) div_q  <= pwdata[7:0];
    end
  end

  // Transmit buffer and its full flag
  assign tx_wr   = wr & (paddr == OFS_TXB) & tx_on;
  assign tx_busy = tx_st_q != TX_IDLE;
  assign tx_end  = txc_q == bit_top;
  assign tx_fin  = (tx_st_q == TX_STOP) & tx_end & (~mode_q[MODE_SL] | txs2_q);
  // Reload at idle or straight out of the last stop bit
  assign tx_load = txf_q & ((tx_st_q == TX_IDLE) | tx_fin);

  always_ff @(posedge clk) begin
    if (rst | ~tx_on) begin
      txf_q <= 1'b0;
      txb_q <= 8'h00;
    end else begin
      if (tx_wr) txb_q <= pwdata[7:0];
      if (tx_wr) txf_q <= 1'b1;
      else if (tx_load) txf_q <= 1'b0;
    end
  end

  // Transmit frame sequencer
  always_ff @(posedge clk) begin
    if (rst | ~tx_on) begin
      tx_st_q <= TX_IDLE;
      txc_q   <= 9'h000;
      txs_q   <= 8'h00;
      txd_q   <= 8'h00;
      txn_q   <= 3'h0;
      txp_q   <= 1'b0;
      txs2_q  <= 1'b0;
    end else begin
      txc_q <= (tx_st_q == TX_IDLE || tx_end) ? 9'h000 : txc_q + 9'h001;
      if (tx_load) begin
        txs_q <= lsb ? chr(txb_q, len8) : rev(txb_q, len8);
        txd_q <= chr(txb_q, len8);
        if (par == PAR_EVEN) txp_q <= ^chr(txb_q, len8);
        else if (par == PAR_ODD) txp_q <= ~^chr(txb_q, len8);
        else txp_q <= 1'b0;
      end
      case (tx_st_q)
        TX_IDLE: begin
          if (tx_load) tx_st_q <= TX_START;
        end
        TX_START: begin
          if (tx_end) begin
            tx_st_q <= TX_DATA;
            txn_q   <= 3'h0;
          end
        end
        TX_DATA: begin
          if (tx_end) begin
            txs_q <= {1'b0, txs_q[7:1]};
            txn_q <= txn_q + 3'h1;
            if (txn_q == last_bit) begin
              tx_st_q <= (par == PAR_NONE) ? TX_STOP : TX_PAR;
              txs2_q  <= 1'b0;
            end
          end
        end
        TX_PAR: begin
          if (tx_end) begin
            tx_st_q <= TX_STOP;
            txs2_q  <= 1'b0;
          end
        end
        TX_STOP: begin
          if (tx_fin) begin
            tx_st_q <= tx_load ? TX_START : TX_IDLE;
          end else if (tx_end) begin
            txs2_q <= 1'b1;
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  // Line driver; power off forces the pin high
  always_ff @(posedge clk) begin
    if (rst | ~pwr) begin
      serial_out_pin <= 1'b1;
    end else begin
      case (tx_st_q)
        TX_START: serial_out_pin <= inv;
        TX_DATA:  serial_out_pin <= txs_q[0] ^ inv;
        TX_PAR:   serial_out_pin <= txp_q ^ inv;
        default:  serial_out_pin <= ~inv;
      endcase
    end
  end

  // Done pulse after the final stop bit
  always_ff @(posedge clk) begin
    if (rst | ~tx_on) tx_done_irq <= 1'b0;
    else tx_done_irq <= tx_fin;
  end

  // Receive frame sequencer
  assign rx_end  = rxc_q == bit_top;
  assign rx_fin  = (rx_st_q == RX_STOP) & rx_end;
  assign rx_data = chr(lsb ? rev(rxs_q, len8) : rxs_q, len8);
  assign rx_errs = {rxpe_q, ~serial_in_pin, unread_q};

  always_ff @(posedge clk) begin
    if (rst | ~rx_on) begin
      rx_st_q  <= RX_IDLE;
      rxc_q    <= 9'h000;
      rxs_q    <= 8'h00;
      rxn_q    <= 3'h0;
      rxx_q    <= 1'b0;
      rxpe_q   <= 1'b0;
      rxprev_q <= 1'b1;
    end else begin
      rxprev_q <= serial_in_pin;
      rxc_q    <= (rx_st_q == RX_IDLE || rx_end) ? 9'h000 : rxc_q + 9'h001;
      case (rx_st_q)
        RX_IDLE: begin
          if (rxprev_q & ~serial_in_pin) rx_st_q <= RX_START;
          rxpe_q <= 1'b0;
          rxx_q  <= 1'b0;
        end
        RX_START: begin
          if (rxc_q == half_top) begin
            rx_st_q <= serial_in_pin ? RX_IDLE : RX_DATA;
            rxc_q   <= 9'h000;
            rxn_q   <= 3'h0;
          end
        end
        RX_DATA: begin
          if (rx_end) begin
            rxs_q <= {rxs_q[6:0], serial_in_pin};
            rxx_q <= rxx_q ^ serial_in_pin;
            rxn_q <= rxn_q + 3'h1;
            if (rxn_q == last_bit) begin
              rx_st_q <= (par == PAR_NONE) ? RX_STOP : RX_PAR;
            end
          end
        end
        RX_PAR: begin
          if (rx_end) begin
            rx_st_q <= RX_STOP;
            if (par == PAR_EVEN) rxpe_q <= rxx_q ^ serial_in_pin;
            else if (par == PAR_ODD) rxpe_q <= ~(rxx_q ^ serial_in_pin);
            else rxpe_q <= 1'b0;
          end
        end
        RX_STOP: begin
          if (rx_end) rx_st_q <= RX_IDLE;
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // Receive buffer, error flags and event pulses
  assign rd_err = rd & (paddr == OFS_ERR);
  // Buffer read frees it only once errors were read out
  assign rd_rxb = rd & (paddr == OFS_RXB) & (err_q == 3'h0);

  always_ff @(posedge clk) begin
    if (rst | ~pwr) begin
      rxb_q        <= RXBUF_RST;
      err_q        <= 3'h0;
      unread_q     <= 1'b0;
      rx_done_irq  <= 1'b0;
      rx_error_irq <= 1'b0;
    end else begin
      // New errors win over a read clear in the same cycle
      err_q <= (rd_err ? 3'h0 : err_q) | (rx_fin ? rx_errs : 3'h0);
      if (rx_fin & ~unread_q) rxb_q <= rx_data;
      unread_q     <= (unread_q & ~rd_rxb) | rx_fin;
      rx_done_irq  <= rx_fin;
      rx_error_irq <= rx_fin & (|rx_errs);
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_tx_last_stop;
    tx_fin;
  endsequence

  sequence s_rx_frame_end;
    rx_fin && rx_on;
  endsequence

  chk_start_level: assert property ((tx_st_q == TX_START && pwr) |=>
    serial_out_pin == $past(inv)) else $error("start bit level wrong");
  chk_even_par: assert property ((tx_st_q == TX_PAR && par == PAR_EVEN) |->
    !(^txd_q ^ txp_q)) else $error("even parity wrong");
  chk_odd_par: assert property ((tx_st_q == TX_PAR && par == PAR_ODD) |->
    (^txd_q ^ txp_q)) else $error("odd parity wrong");
  chk_zero_par: assert property ((s_rx_frame_end and (par < PAR_ODD)) |=>
    !err_q[ERR_PE] || $past(err_q[ERR_PE] && !rd_err)) else $error("parity error without parity");
  chk_done_pulse: assert property (s_tx_last_stop |=> tx_done_irq ##1 !tx_done_irq)
    else $error("transmit done pulse wrong");
  chk_back_to_back: assert property ((s_tx_last_stop and txf_q) |=>
    tx_st_q == TX_START && !txf_q ##1 serial_out_pin == $past(inv))
    else $error("back to back frame lost");
  chk_flag_pair: assert property ((tx_wr && !tx_busy) |=> txf_q && !tx_busy
    ##1 !txf_q && tx_busy) else $error("status flag sequence wrong");
  chk_start_reject: assert property ((rx_st_q == RX_START && rxc_q == half_top
    && serial_in_pin && rx_on) |=> rx_st_q == RX_IDLE) else $error("false start kept");
  chk_rx_copy: assert property ((s_rx_frame_end and !unread_q) |=>
    rxb_q == $past(rx_data) && rx_done_irq) else $error("receive copy lost");
  chk_overrun_keep: assert property ((s_rx_frame_end and unread_q) |=>
    $stable(rxb_q) && err_q[ERR_OVE]) else $error("overrun not handled");
  chk_err_clear: assert property ((rd_err && !rx_fin && pwr) |=> err_q == 3'h0)
    else $error("error flags not cleared");
endmodule
`default_nettype wire

// ===== ufte_pkg.sv
`default_nettype none
package ufte_pkg;
  // APB address width and register byte offsets
  localparam int AW = 8;
  localparam logic [AW-1:0] OFS_MODE = 8'h00;
  localparam logic [AW-1:0] OFS_CTRL = 8'h04;
  localparam logic [AW-1:0] OFS_BAUD = 8'h08;
  localparam logic [AW-1:0] OFS_TXB  = 8'h0c;
  localparam logic [AW-1:0] OFS_RXB  = 8'h10;
  localparam logic [AW-1:0] OFS_TXS  = 8'h14;
  localparam logic [AW-1:0] OFS_ERR  = 8'h18;

  // Mode register fields
  localparam int MODE_PWR  = 7;
  localparam int MODE_TXE  = 6;
  localparam int MODE_RXE  = 5;
  localparam int MODE_PS   = 3;
  localparam int MODE_CL   = 2;
  localparam int MODE_SL   = 1;

  // Control, status and error fields
  localparam int CTRL_DIR  = 1;
  localparam int CTRL_INV  = 0;
  localparam int TXS_FULL  = 1;
  localparam int TXS_BUSY  = 0;
  localparam int ERR_PE    = 2;
  localparam int ERR_FE    = 1;
  localparam int ERR_OVE   = 0;

  // Reset values
  localparam logic [7:0] MODE_RST  = 8'h01;
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] BAUD_RST  = 8'hff;
  localparam logic [7:0] RXBUF_RST = 8'hff;

  // Parity selections
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD  = 2'h2;
  localparam logic [1:0] PAR_EVEN = 2'h3;

  // Character bit counts, minus one
  localparam logic [2:0] LAST8 = 3'h7;
  localparam logic [2:0] LAST7 = 3'h6;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ufte_tx_st_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ufte_rx_st_t;
endpackage
`default_nettype wire

// ===== ufte_node.sv
`default_nettype none
// Remote serial node: listens to the device's line, sends frames back
module ufte_node (
  input  wire logic       clk,
  input  wire logic       tx_line,
  output var  logic       rx_line,
  input  wire logic [7:0] div,
  input  wire logic [1:0] par,
  input  wire logic       cl8,
  input  wire logic       sl2,
  input  wire logic       lsb,
  input  wire logic       inv
);
  timeunit 1ns;
  timeprecision 1ps;
  import ufte_pkg::*;
  logic [9:0] heard[$];

  // Parity bit over the character bits
  function automatic logic pbit(input logic [7:0] d);
    case (par)
      PAR_EVEN: return ^d;
      PAR_ODD:  return ~^d;
      default:  return 1'b0;
    endcase
  endfunction

  // Listener; start confirmed at mid-bit so polarity switches never fake a frame
  always begin
    logic [7:0] d;
    logic       p;
    int         n;
    @(posedge clk iff (tx_line ^ inv) === 1'b0);
    repeat (div) @(posedge clk);
    if ((tx_line ^ inv) === 1'b0) begin
      n = cl8 ? 8 : 7;
      d = '0;
      p = 1'b0;
      for (int i = 0; i < n; i++) begin
        repeat (2 * div) @(posedge clk);
        if (lsb) d[i] = tx_line ^ inv;
        else d[n-1-i] = tx_line ^ inv;
      end
      if (par != PAR_NONE) begin
        repeat (2 * div) @(posedge clk);
        p = tx_line ^ inv;
      end
      repeat (2 * div) @(posedge clk);
      heard.push_back({tx_line ^ inv, p, d}); // Stop, parity, data
    end
  end

  initial rx_line = 1'b1;

  // Short low pulse that must not be taken for a start bit
  task automatic glitch;
    @(posedge clk);
    rx_line <= 1'b0;
    repeat (2) @(posedge clk);
    rx_line <= 1'b1;
    repeat (2 * div) @(posedge clk);
  endtask

  // Sender; bad_p flips parity, bad_s holds the stop low
  task automatic send(input logic [7:0] d, input logic bad_p, input logic bad_s);
    logic q[$];
    int   n;
    n = cl8 ? 8 : 7;
    q.push_back(1'b0);
    for (int i = 0; i < n; i++) q.push_back(lsb ? d[i] : d[n-1-i]);
    if (par != PAR_NONE) q.push_back(pbit(cl8 ? d : {1'b0, d[6:0]}) ^ bad_p);
    q.push_back(~bad_s);
    if (sl2) q.push_back(1'b1);
    q.push_back(1'b1); // Idle gap
    foreach (q[i]) begin
      @(posedge clk);
      rx_line <= q[i];
      repeat (2 * div - 1) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// ===== uart_frame_tx_rx_engine_tb_top.sv
`default_nettype none
module uart_frame_tx_rx_engine_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ufte_pkg::*;
  logic          clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [AW-1:0] paddr = '0;
  logic [31:0]   pwdata = '0, prdata, r;
  logic          pready, pslverr, sin, sout, txd, rxd, rxe, er, pe, fe;
  logic [7:0]    d, e, div = 8'h04;
  logic [1:0]    par = PAR_NONE;
  logic          cl8 = 1'b1, sl2 = 1'b0, lsb = 1'b1, inv = 1'b0;
  int            n_errors = 0, samples_checked = 0, n_txd = 0, n_rxd = 0, n_rxe = 0, k, m;
  logic [7:0]    ra[7] = '{OFS_MODE, OFS_CTRL, OFS_BAUD, OFS_RXB, OFS_TXS, OFS_ERR, 8'h1c};
  logic [7:0]    rv[7] = '{MODE_RST, CTRL_RST, BAUD_RST, RXBUF_RST, 8'h00, 8'h00, 8'h00};

  always #25 clk = ~clk;

  // Event pulse counters
  always @(posedge clk) begin
    if (txd === 1'b1) n_txd++;
    if (rxd === 1'b1) n_rxd++;
    if (rxe === 1'b1) n_rxe++;
  end

  ufte_top dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_in_pin(sin), .serial_out_pin(sout), .tx_done_irq(txd), .rx_done_irq(rxd),
    .rx_error_irq(rxe));
  ufte_node node_u (.clk(clk), .tx_line(sout), .rx_line(sin), .div(div), .par(par),
    .cl8(cl8), .sl2(sl2), .lsb(lsb), .inv(inv));

  task automatic close_out;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    samples_checked++;
    if (got != exp) begin
      n_errors++;
      $display("[FAIL] t=%0t count %h exp %h", $time, got, exp);
    end
  endtask

  // One APB transfer; result left in r and er
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Power stays on; enables set with it
  task automatic cfg(input logic [1:0] p, input logic c, s, l, v);
    apb(1'b1, OFS_MODE, {24'h0, 3'b111, p, c, s, 1'b0});
    apb(1'b1, OFS_CTRL, {30'h0, l, v});
    par = p;
    cl8 = c;
    sl2 = s;
    lsb = l;
    inv = v;
  endtask

  task automatic idle_wait;
    int n;
    n = 0;
    do begin
      apb(1'b0, OFS_TXS, 32'h0);
      n++;
    end while (r[0] !== 1'b0 && n < 200);
    if (r[0] !== 1'b0) n_errors++;
    repeat (4) @(posedge clk);
  endtask

  function automatic logic [7:0] msk(input logic [7:0] x);
    return cl8 ? x : {1'b0, x[6:0]};
  endfunction

  function automatic logic expp(input logic [7:0] x);
    return (par == PAR_EVEN) ? ^x : (par == PAR_ODD) ? ~^x : 1'b0;
  endfunction

  task automatic heard_chk(input logic [7:0] x);
    chk({22'h0, node_u.heard.size() > 0 ? node_u.heard.pop_front() : {10{1'bx}}},
        {22'h0, 1'b1, expp(msk(x)), msk(x)});
  endtask

  initial begin
    void'($urandom(32'hd1f9));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    // Reset values, then an unmapped place refused both ways
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk(r, {24'h0, rv[i]});
      chk({31'h0, er}, {31'h0, i == 6});
    end
    apb(1'b1, 8'h1c, 32'h1);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, OFS_BAUD, {24'h0, div});
    apb(1'b1, OFS_MODE, 32'h80);
    // Outgoing frames over eight parity, length, stop, order and polarity mixes, each parity twice
    for (int i = 0; i < 8; i++) begin
      cfg(i[1:0], i[2], i[0] ^ i[2], i[1] ^ i[2], i[2] & i[1]);
      d = $urandom;
      k = n_txd;
      apb(1'b1, OFS_TXB, {24'h0, d});
      idle_wait;
      heard_chk(d);
      chk_cnt(n_txd, k + 1);
      chk({31'h0, sout}, {31'h0, ~inv});
    end
    // Back to back: second write once full clears, flags then read 11
    cfg(PAR_EVEN, 1'b1, 1'b0, 1'b1, 1'b0);
    k = n_txd;
    d = $urandom;
    e = $urandom;
    apb(1'b1, OFS_TXB, {24'h0, d});
    m = 0;
    do begin
      apb(1'b0, OFS_TXS, 32'h0);
      m++;
    end while (r[1] !== 1'b0 && m < 50);
    chk(r, 32'h1);
    apb(1'b1, OFS_TXB, {24'h0, e});
    apb(1'b0, OFS_TXS, 32'h0);
    chk(r, 32'h3);
    idle_wait;
    chk_cnt(n_txd, k + 2);
    heard_chk(d);
    heard_chk(e);
    // Incoming frames with parity and stop faults
    for (int i = 0; i < 8; i++) begin
      cfg(i[1:0], i[2], i[0], i[1], 1'b0);
      d = $urandom;
      k = n_rxd;
      m = n_rxe;
      pe = i[2] & i[1];
      fe = (i == 1);
      node_u.send(d, i[2], fe);
      chk_cnt(n_rxd, k + 1);
      chk_cnt(n_rxe, m + (pe | fe));
      apb(1'b0, OFS_ERR, 32'h0);
      chk(r, {29'h0, pe, fe, 1'b0});
      apb(1'b0, OFS_ERR, 32'h0);
      chk(r, 32'h0);
      apb(1'b0, OFS_RXB, 32'h0);
      chk(r, {24'h0, msk(d)});
    end
    // Short low pulse on the line is rejected at mid-start
    k = n_rxd;
    node_u.glitch;
    chk_cnt(n_rxd, k);
    // Overrun keeps the older byte
    d = $urandom;
    e = $urandom;
    node_u.send(d, 1'b0, 1'b0);
    node_u.send(e, 1'b0, 1'b0);
    apb(1'b0, OFS_ERR, 32'h0);
    chk(r, 32'h1);
    apb(1'b0, OFS_RXB, 32'h0);
    chk(r, {24'h0, msk(d)});
    // Power off clears buffer and line; writes then ignored
    node_u.send(e, 1'b0, 1'b0);
    apb(1'b1, OFS_MODE, 32'h0);
    apb(1'b0, OFS_RXB, 32'h0);
    chk(r, 32'hff);
    chk({31'h0, sout}, 32'h1);
    apb(1'b1, OFS_TXB, {24'h0, d});
    apb(1'b0, OFS_TXS, 32'h0);
    chk(r, 32'h0);
    close_out;
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    close_out;
  end
endmodule
`default_nettype wire
